// ### inc/lcrb_pkg.sv
// Shared constants for the LCD control register bank and its host end
package lcrb_pkg;
  // Register widths
  localparam int SCRL_W = 6;
  localparam int COL_W = 8;
  localparam int PAGE_W = 4;
  localparam int BIAS_W = 2;
  localparam int TEMP_W = 2;
  localparam int TRIM_W = 8;
  localparam int PWR_W = 3;
  localparam int ADDR_W = 3;
  localparam int DISP_W = 3;
  // Reset values
  localparam logic [SCRL_W-1:0] SCRL_RST = 6'h00;
  localparam logic [COL_W-1:0] COL_RST = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 4'h0;
  localparam logic [BIAS_W-1:0] BIAS_RST = 2'h3;
  localparam logic [TEMP_W-1:0] TEMP_RST = 2'h0;
  localparam logic [TRIM_W-1:0] TRIM_RST = 8'hc0;
  localparam logic [PWR_W-1:0] PWR_RST = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_RST = 3'h1;
  localparam logic [DISP_W-1:0] DISP_RST = 3'h0;
  // Pointer limits, zero based
  localparam logic [COL_W-1:0] COL_MAX = 8'h83;
  localparam logic [PAGE_W-1:0] PAGE_MAX = 4'h8;
  // Field positions
  localparam int ADDR_WRAP = 0;
  localparam int ADDR_ORDER = 1;
  localparam int ADDR_DIR = 2;
  localparam int DISP_INV = 0;
  localparam int DISP_ALL = 1;
  localparam int DISP_ON = 2;
  localparam int PWR_LOAD = 0;
  localparam int PWR_SRC_LO = 1;
  localparam logic [1:0] PWR_SRC_EXT = 2'h0;
  localparam logic [1:0] PWR_SRC_PUMP = 2'h3;
  localparam logic [3:0] BIAS_BASE = 4'h6;
  // Command byte patterns, upper bits compared
  localparam logic [3:0] OP_COL_LSB = 4'h0;
  localparam logic [3:0] OP_COL_MSB = 4'h1;
  localparam logic [5:0] OP_TEMP = 6'h09;
  localparam logic [4:0] OP_PWR = 5'h05;
  localparam logic [1:0] OP_SCRL = 2'h1;
  localparam logic [3:0] OP_PAGE = 4'hb;
  localparam logic [7:0] OP_TRIM = 8'h81;
  localparam logic [5:0] OP_BIAS = 6'h3a;
  localparam logic [4:0] OP_ADDR = 5'h11;
  localparam logic [4:0] OP_DISP = 5'h14;
  localparam logic [7:0] OP_RESET = 8'he2;
  // Host APB map
  localparam logic [7:0] HOST_CMD_ADDR = 8'h00;
  localparam logic [7:0] HOST_STAT_ADDR = 8'h04;
  localparam int HOST_CD_BIT = 8;
endpackage

// ### inc/lcrb_link_if.sv
// Command byte link between host end and register bank
`timescale 1ns/10ps
`default_nettype none
interface lcrb_link_if;
  logic valid;
  logic ready;
  logic cd;
  logic [7:0] data;
  modport dev (input valid, input cd, input data, output ready);
  modport host (output valid, output cd, output data, input ready);
endinterface
`default_nettype wire

// ### design/lcrb_host.sv
// Host end: APB command register feeding the command byte link
`timescale 1ns/10ps
`default_nettype none
module lcrb_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to device
  lcrb_link_if.host lnk
);
  logic pend_r, pend_nxt;
  logic cd_r, cd_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic [7:0] sent_r, sent_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic cmd_hit, stat_hit, acc;

  assign cmd_hit = paddr == lcrb_pkg::HOST_CMD_ADDR;
  assign stat_hit = paddr == lcrb_pkg::HOST_STAT_ADDR;
  assign acc = psel && penable;
  // Stall a command write while a byte still waits, so none is lost
  assign pready = !(cmd_hit && pwrite && pend_r);
  assign pslverr = !(cmd_hit || stat_hit);
  assign prdata = rd_r;
  // Bit 8 of the written word picks whether the byte goes out as command or data
  assign lnk.valid = pend_r;
  assign lnk.cd = cd_r;
  assign lnk.data = byte_r;

  always_comb
  begin
    pend_nxt = pend_r;
    cd_nxt = cd_r;
    byte_nxt = byte_r;
    sent_nxt = sent_r;
    rd_nxt = rd_r;
    if (pend_r && lnk.ready)
    begin
      pend_nxt = 1'b0;
      sent_nxt = sent_r + 8'h01;
    end
    if (acc && pready && pwrite && cmd_hit)
    begin
      pend_nxt = 1'b1;
      byte_nxt = pwdata[7:0];
      cd_nxt = pwdata[lcrb_pkg::HOST_CD_BIT];
    end
    if (psel && !penable && !pwrite)
      rd_nxt = stat_hit ? {16'h0000, sent_r, 7'h00, pend_r} : 32'h0000_0000;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pend_r <= 1'b0;
      cd_r <= 1'b0;
      byte_r <= 8'h00;
      sent_r <= 8'h00;
      rd_r <= 32'h0000_0000;
    end
    else
    begin
      pend_r <= pend_nxt;
      cd_r <= cd_nxt;
      byte_r <= byte_nxt;
      sent_r <= sent_nxt;
      rd_r <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

// ### design/lcrb_dev.sv
// Device end: LCD control register bank with command decode
//
// Functional notes
// - Scroll shifts image up, 0 to 63
// - Scroll range host duty; icon unaffected
// - 8-bit column pointer, host uses 0-131
// - 4-bit page pointer, host uses 0-8
// - Bias code selects ratio 6..9, reset 3
// - Temperature slope code, reset 0
// - 8-bit voltage trim, reset c0
// - Power bit 0 selects panel load
// - Power bits 2:1 select supply, reset 6
// - Address bit 0 enables pointer wrap
// - Address bit 1 picks increment order
// - Address bit 2 sets page direction
// - Display bit 0 inverts pixels
// - Display bit 1 forces all pixels on
// - Display bit 2 on; off means sleep
// - Electrode indices are zero based
// - Defaults load on power and soft reset
// - Host writes registers only by commands
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module lcrb_dev (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link from host
  lcrb_link_if.dev lnk,
  // Display memory write
  output logic ram_wr,
  output logic [7:0] ram_wdata,
  output logic [lcrb_pkg::COL_W-1:0] ram_col,
  output logic [lcrb_pkg::PAGE_W-1:0] ram_page,
  // Scan path
  input wire logic [lcrb_pkg::SCRL_W-1:0] scan_row,
  input wire logic pixel_in,
  input wire logic icon_in,
  output logic [lcrb_pkg::SCRL_W-1:0] mem_row,
  output logic pixel_out,
  output logic icon_driver_output,
  // Register values
  output logic [lcrb_pkg::SCRL_W-1:0] scroll_line_offset,
  output logic [lcrb_pkg::COL_W-1:0] ram_column_pointer,
  output logic [lcrb_pkg::PAGE_W-1:0] ram_row_group_pointer,
  output logic [lcrb_pkg::BIAS_W-1:0] drive_bias_ratio,
  output logic [lcrb_pkg::TEMP_W-1:0] temperature_slope,
  output logic [lcrb_pkg::TRIM_W-1:0] lcd_voltage_trim,
  output logic [lcrb_pkg::PWR_W-1:0] power_setup,
  output logic [lcrb_pkg::ADDR_W-1:0] addr_step_config,
  output logic [lcrb_pkg::DISP_W-1:0] display_config,
  // Decoded controls
  output logic [3:0] bias_ratio_value,
  output logic heavy_load,
  output logic ext_vlcd,
  output logic pump_on,
  output logic display_on,
  output logic sleep_mode
);
  localparam int SW = lcrb_pkg::SCRL_W;
  localparam int CW = lcrb_pkg::COL_W;
  localparam int PW = lcrb_pkg::PAGE_W;

  logic [SW-1:0] scrl_r, scrl_nxt;
  logic [CW-1:0] col_r, col_nxt;
  logic [PW-1:0] page_r, page_nxt;
  logic [lcrb_pkg::BIAS_W-1:0] bias_r, bias_nxt;
  logic [lcrb_pkg::TEMP_W-1:0] temp_r, temp_nxt;
  logic [lcrb_pkg::TRIM_W-1:0] trim_r, trim_nxt;
  logic [lcrb_pkg::PWR_W-1:0] pwr_r, pwr_nxt;
  logic [lcrb_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [lcrb_pkg::DISP_W-1:0] disp_r, disp_nxt;
  logic trim_pend_r, trim_pend_nxt;
  logic wr_r, wr_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic [CW-1:0] wc_r, wc_nxt;
  logic [PW-1:0] wp_r, wp_nxt;
  logic [SW-1:0] row_r, row_nxt;
  logic pix_r, pix_nxt;
  logic icon_r, icon_nxt;
  logic take;
  logic [7:0] b;
  logic wrap, dir;

  // Column step; end of row reports a carry
  function automatic logic [CW:0] col_step(input logic [CW-1:0] c);
    if (c >= lcrb_pkg::COL_MAX)
      col_step = {1'b1, {CW{1'b0}}};
    else
      col_step = {1'b0, c + {{(CW-1){1'b0}}, 1'b1}};
  endfunction

  // Page step in the chosen direction; leaving 0..8 reports a carry
  function automatic logic [PW:0] page_step(input logic [PW-1:0] p,
                                            input logic down);
    if (!down && p >= lcrb_pkg::PAGE_MAX)
      page_step = {1'b1, {PW{1'b0}}};
    else if (down && (p == {PW{1'b0}} || p > lcrb_pkg::PAGE_MAX))
      page_step = {1'b1, lcrb_pkg::PAGE_MAX};
    else if (down)
      page_step = {1'b0, p - {{(PW-1){1'b0}}, 1'b1}};
    else
      page_step = {1'b0, p + {{(PW-1){1'b0}}, 1'b1}};
  endfunction

  assign lnk.ready = 1'b1;
  assign take = lnk.valid && lnk.ready;
  assign b = lnk.data;
  assign wrap = addr_r[lcrb_pkg::ADDR_WRAP];
  assign dir = addr_r[lcrb_pkg::ADDR_DIR];

  always_comb
  begin
    logic [CW:0] cs;
    logic [PW:0] ps;
    cs = col_step(col_r);
    ps = page_step(page_r, dir);
    scrl_nxt = scrl_r;
    col_nxt = col_r;
    page_nxt = page_r;
    bias_nxt = bias_r;
    temp_nxt = temp_r;
    trim_nxt = trim_r;
    pwr_nxt = pwr_r;
    addr_nxt = addr_r;
    disp_nxt = disp_r;
    trim_pend_nxt = trim_pend_r;
    wr_nxt = 1'b0;
    wd_nxt = wd_r;
    wc_nxt = wc_r;
    wp_nxt = wp_r;
    // Every field loads only on an accepted byte; the column pointer takes one nibble per command
    if (take && lnk.cd)
    begin
      wr_nxt = 1'b1;
      wd_nxt = b;
      wc_nxt = col_r;
      wp_nxt = page_r;
      if (!addr_r[lcrb_pkg::ADDR_ORDER])
      begin
        if (!cs[CW])
          col_nxt = cs[CW-1:0];
        else if (wrap)
        begin
          col_nxt = cs[CW-1:0];
          page_nxt = ps[PW-1:0];
        end
      end
      else
      begin
        if (!ps[PW])
          page_nxt = ps[PW-1:0];
        else if (wrap)
        begin
          page_nxt = ps[PW-1:0];
          col_nxt = cs[CW-1:0];
        end
      end
    end
    else if (take && trim_pend_r)
    begin
      // Second byte of the trim command
      trim_nxt = b;
      trim_pend_nxt = 1'b0;
    end
    else if (take)
    begin
      if (b == lcrb_pkg::OP_RESET)
      begin
        scrl_nxt = lcrb_pkg::SCRL_RST;
        col_nxt = lcrb_pkg::COL_RST;
        page_nxt = lcrb_pkg::PAGE_RST;
        bias_nxt = lcrb_pkg::BIAS_RST;
        temp_nxt = lcrb_pkg::TEMP_RST;
        trim_nxt = lcrb_pkg::TRIM_RST;
        pwr_nxt = lcrb_pkg::PWR_RST;
        addr_nxt = lcrb_pkg::ADDR_RST;
        disp_nxt = lcrb_pkg::DISP_RST;
      end
      else if (b == lcrb_pkg::OP_TRIM)
        trim_pend_nxt = 1'b1;
      else if (b[7:4] == lcrb_pkg::OP_COL_LSB)
        col_nxt = {col_r[7:4], b[3:0]};
      else if (b[7:4] == lcrb_pkg::OP_COL_MSB)
        col_nxt = {b[3:0], col_r[3:0]};
      else if (b[7:2] == lcrb_pkg::OP_TEMP)
        temp_nxt = b[1:0];
      else if (b[7:3] == lcrb_pkg::OP_PWR)
        pwr_nxt = b[2:0];
      else if (b[7:6] == lcrb_pkg::OP_SCRL)
        scrl_nxt = b[5:0];
      else if (b[7:4] == lcrb_pkg::OP_PAGE)
        page_nxt = b[3:0];
      else if (b[7:2] == lcrb_pkg::OP_BIAS)
        bias_nxt = b[1:0];
      else if (b[7:3] == lcrb_pkg::OP_ADDR)
        addr_nxt = b[2:0];
      else if (b[7:3] == lcrb_pkg::OP_DISP)
        disp_nxt = b[2:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scrl_r <= lcrb_pkg::SCRL_RST;
      col_r <= lcrb_pkg::COL_RST;
      page_r <= lcrb_pkg::PAGE_RST;
      bias_r <= lcrb_pkg::BIAS_RST;
      temp_r <= lcrb_pkg::TEMP_RST;
      trim_r <= lcrb_pkg::TRIM_RST;
      pwr_r <= lcrb_pkg::PWR_RST;
      addr_r <= lcrb_pkg::ADDR_RST;
      disp_r <= lcrb_pkg::DISP_RST;
      trim_pend_r <= 1'b0;
      wr_r <= 1'b0;
      wd_r <= 8'h00;
      wc_r <= lcrb_pkg::COL_RST;
      wp_r <= lcrb_pkg::PAGE_RST;
    end
    else
    begin
      scrl_r <= scrl_nxt;
      col_r <= col_nxt;
      page_r <= page_nxt;
      bias_r <= bias_nxt;
      temp_r <= temp_nxt;
      trim_r <= trim_nxt;
      pwr_r <= pwr_nxt;
      addr_r <= addr_nxt;
      disp_r <= disp_nxt;
      trim_pend_r <= trim_pend_nxt;
      wr_r <= wr_nxt;
      wd_r <= wd_nxt;
      wc_r <= wc_nxt;
      wp_r <= wp_nxt;
    end
  end

  // Scan path: one cycle from scan_row and pixel_in to outputs
  always_comb
  begin
    // Row index wraps modulo 64, rows zero based
    row_nxt = scan_row + scrl_r;
    if (!disp_r[lcrb_pkg::DISP_ON])
      pix_nxt = 1'b0;
    else if (disp_r[lcrb_pkg::DISP_ALL])
      pix_nxt = 1'b1;
    else
      pix_nxt = pixel_in ^ disp_r[lcrb_pkg::DISP_INV];
    // Icon never goes through the scroll offset
    icon_nxt = icon_in && disp_r[lcrb_pkg::DISP_ON];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      row_r <= {SW{1'b0}};
      pix_r <= 1'b0;
      icon_r <= 1'b0;
    end
    else
    begin
      row_r <= row_nxt;
      pix_r <= pix_nxt;
      icon_r <= icon_nxt;
    end
  end

  assign ram_wr = wr_r;
  assign ram_wdata = wd_r;
  assign ram_col = wc_r;
  assign ram_page = wp_r;
  assign mem_row = row_r;
  assign pixel_out = pix_r;
  assign icon_driver_output = icon_r;
  assign scroll_line_offset = scrl_r;
  assign ram_column_pointer = col_r;
  assign ram_row_group_pointer = page_r;
  assign drive_bias_ratio = bias_r;
  assign temperature_slope = temp_r;
  assign lcd_voltage_trim = trim_r;
  assign power_setup = pwr_r;
  assign addr_step_config = addr_r;
  assign display_config = disp_r;
  assign bias_ratio_value = lcrb_pkg::BIAS_BASE + {2'b00, bias_r};
  assign heavy_load = pwr_r[lcrb_pkg::PWR_LOAD];
  assign ext_vlcd = pwr_r[lcrb_pkg::PWR_SRC_LO+1 -: 2] ==
    lcrb_pkg::PWR_SRC_EXT;
  assign pump_on = pwr_r[lcrb_pkg::PWR_SRC_LO+1 -: 2] ==
    lcrb_pkg::PWR_SRC_PUMP;
  assign display_on = disp_r[lcrb_pkg::DISP_ON];
  assign sleep_mode = !disp_r[lcrb_pkg::DISP_ON];
endmodule
`default_nettype wire

// ### bench/lcrb_chk_sva.sv
// Concurrent checks on the command link and the register bank outputs
`timescale 1ns/10ps
`default_nettype none
module lcrb_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  input wire logic valid,
  input wire logic ready,
  input wire logic cd,
  input wire logic [7:0] data,
  // Bank outputs
  input wire logic [5:0] scroll_line_offset,
  input wire logic [7:0] ram_column_pointer,
  input wire logic [1:0] drive_bias_ratio,
  input wire logic [7:0] lcd_voltage_trim,
  input wire logic [2:0] power_setup,
  input wire logic [2:0] display_config,
  input wire logic [3:0] bias_ratio_value,
  input wire logic heavy_load,
  input wire logic ext_vlcd,
  input wire logic pump_on,
  input wire logic display_on,
  input wire logic sleep_mode,
  input wire logic ram_wr,
  input wire logic [7:0] ram_wdata,
  input wire logic [7:0] ram_col,
  input wire logic [3:0] ram_page,
  input wire logic [3:0] ram_row_group_pointer,
  input wire logic [5:0] scan_row,
  input wire logic [5:0] mem_row
);
  logic pend_r;
  logic pend_nxt;
  logic cmd;
  logic dflt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Byte after the trim opcode is a value, never a command
  always_comb
  begin
    pend_nxt = pend_r;
    if (valid && ready && !cd)
      pend_nxt = pend_r ? 1'b0 : (data == lcrb_pkg::OP_TRIM);
  end
  always_ff @(posedge clk)
    pend_r <= rst_n ? pend_nxt : 1'b0;
  assign cmd = valid && ready && !cd && !pend_r;
  assign dflt = lcd_voltage_trim == lcrb_pkg::TRIM_RST &&
    drive_bias_ratio == lcrb_pkg::BIAS_RST &&
    power_setup == lcrb_pkg::PWR_RST &&
    display_config == lcrb_pkg::DISP_RST && scroll_line_offset == 6'h00 &&
    ram_column_pointer == 8'h00;
  a_rst_defaults: assert property ($rose(rst_n) |-> dflt)
    else $error("defaults missing after reset");
  a_soft_defaults: assert property (cmd && data == 8'he2 |=> dflt)
    else $error("defaults missing after soft reset");
  a_scroll_load: assert property (cmd && data[7:6] == 2'h1 |=>
    scroll_line_offset == $past(data[5:0])) else $error("scroll not loaded");
  a_trim_pair: assert property (valid && !cd && pend_r |=>
    lcd_voltage_trim == $past(data)) else $error("trim value not loaded");
  a_col_msb: assert property (cmd && data[7:4] == 4'h1 |=>
    ram_column_pointer == {$past(data[3:0]), $past(ram_column_pointer[3:0])})
    else $error("column high nibble wrong");
  a_bias_ratio: assert property (bias_ratio_value ==
    4'h6 + {2'h0, drive_bias_ratio}) else $error("bias ratio wrong");
  a_power_decode: assert property (heavy_load == power_setup[0] &&
    ext_vlcd == (power_setup[2:1] == 2'h0) && pump_on == &power_setup[2:1])
    else $error("power decode wrong");
  a_sleep_flag: assert property (display_on == display_config[2] &&
    sleep_mode == !display_config[2]) else $error("sleep flag wrong");
  a_data_write: assert property (valid && cd |=> ram_wr &&
    ram_wdata == $past(data) && ram_col == $past(ram_column_pointer) &&
    ram_page == $past(ram_row_group_pointer))
    else $error("memory write wrong");
  a_mem_row: assert property ($past(rst_n) |-> mem_row ==
    6'($past(scan_row) + $past(scroll_line_offset))) else $error("row wrong");
endmodule
`default_nettype wire

// ### bench/lcrb_control_register_bank_test.sv
// Self-checking bench for host end and register bank
`timescale 1ns/10ps
`default_nettype none
module lcd_control_register_bank_test;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic ram_wr, pixel_in, icon_in, pixel_out, icon_driver_output;
  logic heavy_load, ext_vlcd, pump_on, display_on, sleep_mode;
  logic [7:0] ram_wdata, ram_col, ram_column_pointer, lcd_voltage_trim;
  logic [5:0] scan_row, mem_row, scroll_line_offset;
  logic [3:0] ram_page, ram_row_group_pointer, bias_ratio_value;
  logic [1:0] drive_bias_ratio, temperature_slope;
  logic [2:0] power_setup, addr_step_config, display_config;
  int fails = 0;
  int total_checks = 0;
  logic [7:0] defs [9] = '{8'h00, 8'h00, 8'h00, 8'h09, 8'h00, 8'h16, 8'h01,
    8'h08, 8'hc0};
  // cd nibble, byte, result select, expected
  logic [23:0] rows [41] = '{24'h07f03f, 24'h040000, 24'h003103, 24'h018183,
    24'h0b8208, 24'h0e8306, 24'h0e9307, 24'h0ea308, 24'h0eb309, 24'h024400,
    24'h025401, 24'h026402, 24'h027403, 24'h028520, 24'h02f51f, 24'h02b50b,
    24'h08e606, 24'h0a5715, 24'h0a270a, 24'h0818c0, 24'h1338c0, 24'h055855,
    24'h0a5902, 24'h0a6903, 24'h07f903, 24'h0a2900, 24'h089601, 24'h0b2202,
    24'h018183, 24'h1aaa30, 24'h1aaa31, 24'h088600, 24'h018181, 24'h003183,
    24'h1aa183, 24'h08b603, 24'h0b8208, 24'h1aaa00, 24'h08f607, 24'h1aaa81,
    24'h1aaa71};
  lcrb_link_if lnk();
  lcrb_host lcrb_host_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  lcrb_dev lcrb_dev_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk),
    .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_col(ram_col),
    .ram_page(ram_page), .scan_row(scan_row), .pixel_in(pixel_in),
    .icon_in(icon_in), .mem_row(mem_row), .pixel_out(pixel_out),
    .icon_driver_output(icon_driver_output),
    .scroll_line_offset(scroll_line_offset),
    .ram_column_pointer(ram_column_pointer),
    .ram_row_group_pointer(ram_row_group_pointer),
    .drive_bias_ratio(drive_bias_ratio), .temperature_slope(temperature_slope),
    .lcd_voltage_trim(lcd_voltage_trim), .power_setup(power_setup),
    .addr_step_config(addr_step_config), .display_config(display_config),
    .bias_ratio_value(bias_ratio_value), .heavy_load(heavy_load),
    .ext_vlcd(ext_vlcd), .pump_on(pump_on), .display_on(display_on),
    .sleep_mode(sleep_mode));
  lcrb_chk lcrb_chk_inst (.clk(clk), .rst_n(rst_n), .valid(lnk.valid),
    .ready(lnk.ready), .cd(lnk.cd), .data(lnk.data),
    .scroll_line_offset(scroll_line_offset),
    .ram_column_pointer(ram_column_pointer),
    .drive_bias_ratio(drive_bias_ratio), .lcd_voltage_trim(lcd_voltage_trim),
    .power_setup(power_setup), .display_config(display_config),
    .bias_ratio_value(bias_ratio_value), .heavy_load(heavy_load),
    .ext_vlcd(ext_vlcd), .pump_on(pump_on), .display_on(display_on),
    .sleep_mode(sleep_mode), .ram_wr(ram_wr), .ram_wdata(ram_wdata),
    .ram_col(ram_col), .ram_page(ram_page),
    .ram_row_group_pointer(ram_row_group_pointer),
    .scan_row(scan_row), .mem_row(mem_row));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Moving scan row keeps the scroll adder busy
  always @(posedge clk)
    scan_row <= scan_row + 6'h01;
  function automatic logic [7:0] rv(input logic [3:0] i);
    case (i)
      4'h0: rv = {2'h0, scroll_line_offset};
      4'h1: rv = ram_column_pointer;
      4'h2: rv = {4'h0, ram_row_group_pointer};
      4'h3: rv = {4'h0, bias_ratio_value};
      4'h4: rv = {6'h0, temperature_slope};
      4'h5: rv = {2'h0, ext_vlcd, pump_on, heavy_load, power_setup};
      4'h6: rv = {5'h0, addr_step_config};
      4'h7: rv = {3'h0, display_on, sleep_mode, display_config};
      4'h8: rv = lcd_voltage_trim;
      4'h9: rv = {6'h0, icon_driver_output, pixel_out};
      default: rv = {ram_row_group_pointer, ram_column_pointer[3:0]};
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
    input string m);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Ready is judged mid-cycle, settled before the edge that takes it
    @(negedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge clk);
    end
    if (n >= 50)
      fails++;
    @(posedge clk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Three cycles cover the link hop and the register load
  task automatic send(input logic c, input logic [7:0] b);
    apb(1'b1, 8'h00, {23'h0, c, b});
    repeat (3) @(posedge clk);
  endtask
  task automatic check_defaults;
    for (int i = 0; i < 9; i++)
      chk(rv(4'(i)), defs[i], "default");
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    complete_run;
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, scan_row} = '0;
    {pixel_in, icon_in} = 2'h3;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_defaults;
    foreach (rows[i])
    begin
      send(rows[i][20], rows[i][19:12]);
      chk(rv(rows[i][11:8]), rows[i][7:0], "row");
    end
    // Reset opcode after the trim opcode is only a value
    send(1'b0, 8'h81);
    send(1'b0, 8'he2);
    chk(lcd_voltage_trim, 8'he2, "trim pair");
    send(1'b0, 8'he2);
    check_defaults;
    apb(1'b1, 8'h08, 32'h0e2);
    chk({7'h0, err}, 8'h01, "unmapped");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_defaults;
    send(1'b0, 8'h40);
    send(1'b0, 8'h41);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdata[15:8], 8'h02, "sent count");
    complete_run;
  end
endmodule
`default_nettype wire
